// file: design/plpu_pkg.sv
// Package with addresses, field masks, reset values and operation codes of the port block
package plpu_pkg;

  // Address of the port's own latch register (port one by default)
  localparam logic [15:0] PORT_LATCH_ADDR = 16'hFF01;

  // Pull-up select register addresses
  localparam logic [15:0] PU_PORT0_ADDR = 16'hFF30;
  localparam logic [15:0] PU_PORT1_ADDR = 16'hFF31;
  localparam logic [15:0] PU_PORT3_ADDR = 16'hFF33;
  localparam logic [15:0] PU_PORT7_ADDR = 16'hFF37;
  localparam logic [15:0] PU_PORT12_ADDR = 16'hFF3C;
  localparam logic [15:0] PU_PORT14_ADDR = 16'hFF3E;

  // Implemented bits of each pull-up select register; the rest read zero
  localparam logic [7:0] PU_PORT0_MASK = 8'h0F;
  localparam logic [7:0] PU_PORT1_MASK = 8'hFF;
  localparam logic [7:0] PU_PORT3_MASK = 8'h0F;
  localparam logic [7:0] PU_PORT7_MASK = 8'hFF;
  localparam logic [7:0] PU_PORT12_MASK = 8'h01;
  localparam logic [7:0] PU_PORT14_MASK = 8'h01;

  // Reset values
  localparam logic [7:0] PU_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Port numbers that choose where the pull-up bits come from
  localparam int PORT_NUM_0 = 0;
  localparam int PORT_NUM_1 = 1;
  localparam int PORT_NUM_3 = 3;
  localparam int PORT_NUM_6 = 6;
  localparam int PORT_NUM_7 = 7;
  localparam int PORT_NUM_12 = 12;
  localparam int PORT_NUM_14 = 14;

  // Direction bit encoding
  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT = 1'b1;

  // Write operation codes: plain store or read-modify-write
  typedef enum logic [1:0] {
    PLPU_OP_MOV = 2'h0,
    PLPU_OP_AND = 2'h1,
    PLPU_OP_OR = 2'h3,
    PLPU_OP_XOR = 2'h2
  } plpu_op_e;

endpackage

// file: design/plpu_port.sv
// Eight-bit port: output latch, direction-aware read, read-modify-write and pull-up selection
////////////////////////////////////////////////////////////////////////////////
module plpu_port #(
  parameter int PORT_NUM = 1,
  parameter logic [15:0] LATCH_ADDR = plpu_pkg::PORT_LATCH_ADDR,
  parameter logic [7:0] PIN_MASK = 8'hFF,
  parameter logic [7:0] MASK_OPTION_PULLUP = 8'h00
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [1:0] cpu_op,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [7:0] pin_direction_bit,
  input wire logic [7:0] alt_out_active,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pullup_on
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Address match used by every register
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction

  // Per-pin read value: latch in output mode, pin level in input mode
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pins);
    return (dir & pins) | (~dir & latch);
  endfunction

  // Whole-byte modify; an unknown code falls back to a plain store
  function automatic logic [7:0] modify(input logic [1:0] op, input logic [7:0] opd,
                                        input logic [7:0] wd);
    logic [7:0] res;
    case (plpu_pkg::plpu_op_e'(op))
      plpu_pkg::PLPU_OP_MOV: res = wd;
      plpu_pkg::PLPU_OP_AND: res = opd & wd;
      plpu_pkg::PLPU_OP_OR: res = opd | wd;
      plpu_pkg::PLPU_OP_XOR: res = opd ^ wd;
      default: res = wd;
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, a change counts once stages two and three agree

  logic [7:0] sync1_reg, sync2_reg, sync3_reg, pin_level_reg;
  logic [7:0] pin_level_next;
  logic [7:0] stages_agree;

  // A bit whose last two stages differ is still settling and keeps its old level
  // Limitation: a pin toggling every cycle never settles and keeps its last level
  assign stages_agree = sync2_reg ~^ sync3_reg;

  // Filtered level only moves on bits where the last two stages agree
  always_comb begin
    pin_level_next = (pin_level_reg & ~stages_agree) | (sync3_reg & stages_agree);
  end

  // Stage one feeds stage two only, so metastability never reaches logic
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= plpu_pkg::READ_ZERO;
      sync2_reg <= plpu_pkg::READ_ZERO;
      sync3_reg <= plpu_pkg::READ_ZERO;
      pin_level_reg <= plpu_pkg::READ_ZERO;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_level_reg <= pin_level_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic hit_latch;
  logic hit_pu0;
  logic hit_pu1;
  logic hit_pu3;
  logic hit_pu7;
  logic hit_pullup_select_port12;
  logic hit_pullup_select_port14;

  // One comparator per register, shared by the write and the read path
  assign hit_latch = hit(cpu_addr, LATCH_ADDR);
  assign hit_pu0 = hit(cpu_addr, plpu_pkg::PU_PORT0_ADDR);
  assign hit_pu1 = hit(cpu_addr, plpu_pkg::PU_PORT1_ADDR);
  assign hit_pu3 = hit(cpu_addr, plpu_pkg::PU_PORT3_ADDR);
  assign hit_pu7 = hit(cpu_addr, plpu_pkg::PU_PORT7_ADDR);
  assign hit_pullup_select_port12 = hit(cpu_addr, plpu_pkg::PU_PORT12_ADDR);
  assign hit_pullup_select_port14 = hit(cpu_addr, plpu_pkg::PU_PORT14_ADDR);

  logic pu0_wr;
  logic pu1_wr;
  logic pu3_wr;
  logic pu7_wr;
  logic pullup_select_port12_wr;
  logic pullup_select_port14_wr;

  // Write enables; a write to any other address is dropped without effect
  assign pu0_wr = cpu_wr && hit_pu0;
  assign pu1_wr = cpu_wr && hit_pu1;
  assign pu3_wr = cpu_wr && hit_pu3;
  assign pu7_wr = cpu_wr && hit_pu7;
  assign pullup_select_port12_wr = cpu_wr && hit_pullup_select_port12;
  assign pullup_select_port14_wr = cpu_wr && hit_pullup_select_port14;

  ////////////////////////////////////////////////////////////////////////////////
  // Output latch

  logic [7:0] latch_reg, latch_next;
  logic [7:0] operand;
  logic latch_wr;

  assign latch_wr = cpu_wr && hit_latch;

  // Latch update; plain stores and read-modify-write both rewrite the full byte
  always_comb begin
    operand = port_view(pin_direction_bit, latch_reg, pin_level_reg);
    latch_next = latch_reg;
    if (latch_wr) begin
      // store in either mode
      // A bit instruction on a mixed port copies input pin levels into the latch
      latch_next = modify(cpu_op, operand, cpu_wdata) & PIN_MASK;
    end
  end

  // Latch register
  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_reg <= plpu_pkg::LATCH_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pull-up select registers

  logic [7:0] pu0_reg, pu1_reg, pu3_reg, pu7_reg, pullup_select_port12_reg, pullup_select_port14_reg;
  logic [7:0] pu0_next, pu1_next, pu3_next, pu7_next, pullup_select_port12_next, pullup_select_port14_next;

  // Plain stores only; unimplemented bits stay zero
  always_comb begin
    pu0_next = pu0_reg;
    pu1_next = pu1_reg;
    pu3_next = pu3_reg;
    pu7_next = pu7_reg;
    pullup_select_port12_next = pullup_select_port12_reg;
    pullup_select_port14_next = pullup_select_port14_reg;
    // Pull-up registers ignore the operation code: a modify write lands as a plain store
    if (pu0_wr) begin
      pu0_next = cpu_wdata & plpu_pkg::PU_PORT0_MASK;
    end
    if (pu1_wr) begin
      pu1_next = cpu_wdata & plpu_pkg::PU_PORT1_MASK;
    end
    if (pu3_wr) begin
      pu3_next = cpu_wdata & plpu_pkg::PU_PORT3_MASK;
    end
    if (pu7_wr) begin
      pu7_next = cpu_wdata & plpu_pkg::PU_PORT7_MASK;
    end
    if (pullup_select_port12_wr) begin
      pullup_select_port12_next = cpu_wdata & plpu_pkg::PU_PORT12_MASK;
    end
    if (pullup_select_port14_wr) begin
      pullup_select_port14_next = cpu_wdata & plpu_pkg::PU_PORT14_MASK;
    end
  end

  // Pull-up registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      pu0_reg <= plpu_pkg::PU_RESET;
      pu1_reg <= plpu_pkg::PU_RESET;
      pu3_reg <= plpu_pkg::PU_RESET;
      pu7_reg <= plpu_pkg::PU_RESET;
      pullup_select_port12_reg <= plpu_pkg::PU_RESET;
      pullup_select_port14_reg <= plpu_pkg::PU_RESET;
    end else begin
      pu0_reg <= pu0_next;
      pu1_reg <= pu1_next;
      pu3_reg <= pu3_next;
      pu7_reg <= pu7_next;
      pullup_select_port12_reg <= pullup_select_port12_next;
      pullup_select_port14_reg <= pullup_select_port14_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pull-up source for this port

  logic [7:0] pu_sel;

  // Port six has no software register; its pattern is a build-time mask option
  // Only this choice depends on PORT_NUM; all six registers stay readable and writable
  always_comb begin
    case (PORT_NUM)
      plpu_pkg::PORT_NUM_0: pu_sel = pu0_reg;
      plpu_pkg::PORT_NUM_1: pu_sel = pu1_reg;
      plpu_pkg::PORT_NUM_3: pu_sel = pu3_reg;
      plpu_pkg::PORT_NUM_7: pu_sel = pu7_reg;
      plpu_pkg::PORT_NUM_12: pu_sel = pullup_select_port12_reg;
      plpu_pkg::PORT_NUM_14: pu_sel = pullup_select_port14_reg;
      plpu_pkg::PORT_NUM_6: pu_sel = MASK_OPTION_PULLUP;
      default: pu_sel = plpu_pkg::READ_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive and pull-up outputs

  assign pin_oe = ~pin_direction_bit & PIN_MASK;
  // The latch shows on pin_out in both modes; only pin_oe decides whether it drives
  // pin shows latch
  assign pin_out = latch_reg;

  logic [7:0] pull_allowed;

  assign pull_allowed = pin_direction_bit & ~alt_out_active & PIN_MASK;
  assign pullup_on = pu_sel & pull_allowed;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] rdata_reg, rdata_next;

  // Registered read; unmapped addresses return zero
  // A read and a write in one cycle: the read shows the values before the write
  always_comb begin
    rdata_next = rdata_reg;
    if (cpu_rd) begin
      rdata_next = plpu_pkg::READ_ZERO;
      if (hit_latch) begin
        rdata_next = port_view(pin_direction_bit, latch_reg, pin_level_reg) & PIN_MASK;
      end
      if (hit_pu0) begin
        rdata_next = pu0_reg;
      end
      if (hit_pu1) begin
        rdata_next = pu1_reg;
      end
      if (hit_pu3) begin
        rdata_next = pu3_reg;
      end
      if (hit_pu7) begin
        rdata_next = pu7_reg;
      end
      if (hit_pullup_select_port12) begin
        rdata_next = pullup_select_port12_reg;
      end
      if (hit_pullup_select_port14) begin
        rdata_next = pullup_select_port14_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= plpu_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign cpu_rdata = rdata_reg;

endmodule

// file: dv/plpu_port_props.sv
// Checker of the port block's port timing relations
module plpu_port_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [1:0] cpu_op,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic [7:0] pin_direction_bit,
  input wire logic [7:0] alt_out_active,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Write to the latch address
  sequence s_lat_wr;
    cpu_wr && cpu_addr == plpu_pkg::PORT_LATCH_ADDR;
  endsequence
  a_oe_follows_dir: assert property (pin_oe == ~pin_direction_bit) else $error("oe wrong");
  a_pullup_gate_ok: assert property ((pullup_on & ~(pin_direction_bit & ~alt_out_active)) == 8'h00)
    else $error("pullup wrong");
  a_reset_clears_latch: assert property (disable iff (1'b0) reset |=> pin_out == 8'h00)
    else $error("latch not cleared");
  a_store_to_latch: assert property (s_lat_wr ##0 cpu_op == plpu_pkg::PLPU_OP_MOV
    |=> pin_out == $past(cpu_wdata)) else $error("store wrong");
  a_and_on_latch: assert property (s_lat_wr ##0 (cpu_op == plpu_pkg::PLPU_OP_AND
    && pin_direction_bit == 8'h00) |=> pin_out == ($past(pin_out) & $past(cpu_wdata)))
    else $error("modify wrong");
  a_latch_holds: assert property (!cpu_wr |=> $stable(pin_out)) else $error("latch moved");
  a_read_gives_latch: assert property (cpu_rd && !cpu_wr && pin_direction_bit == 8'h00
    && cpu_addr == plpu_pkg::PORT_LATCH_ADDR |=> cpu_rdata == $past(pin_out))
    else $error("read wrong");
  a_rdata_stands: assert property (!cpu_rd |=> $stable(cpu_rdata)) else $error("rdata moved");
  a_unmapped_zero: assert property (cpu_rd && cpu_addr == 16'hFF20 |=> cpu_rdata == 8'h00)
    else $error("unmapped nonzero");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind plpu_port plpu_port_props plpu_port_props_inst (.mclk, .reset, .cpu_addr, .cpu_wr,
  .cpu_op, .cpu_rd, .cpu_wdata, .cpu_rdata, .pin_direction_bit, .alt_out_active, .pin_out,
  .pin_oe, .pullup_on);

// file: dv/plpu_pins_model.sv
// Model of the external circuitry on the eight port pins
module plpu_pins_model (
  input wire logic mclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] ext_drive,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_pat = 8'h55;
  // Floating pins toggle every cycle, so the port never settles on them and keeps their last settled level
  always @(posedge mclk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_drive[i]) pin_in[i] = ext_level[i];
      else if (pullup_on[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_pat[i];
    end
  end
endmodule

// file: dv/test_plpu_port.sv
// Self-checking bench for the port block
module test_plpu_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, cpu_wr = 0, cpu_rd = 0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [1:0] cpu_op = 2'h0;
  logic [7:0] cpu_wdata = 8'h00, dir = 8'hFF, alt = 8'h00, drv = 8'h00, lvl = 8'h00;
  logic [7:0] cpu_rdata, pin_in, pin_out, pin_oe, pullup_on;
  int num_errors = 0, cmp_count = 0;
  logic [15:0] pu_addr [6] = '{16'hFF30, 16'hFF31, 16'hFF33, 16'hFF37, 16'hFF3C, 16'hFF3E};
  logic [7:0] pu_mask [6] = '{8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h01, 8'h01};
  always #50 mclk = ~mclk;
  plpu_port plpu_port_inst (.mclk(mclk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_op(cpu_op), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .pin_direction_bit(dir), .alt_out_active(alt), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on));
  plpu_pins_model plpu_pins_model_inst (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_drive(drv), .ext_level(lvl), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe, then settle
  task automatic wr(input logic [15:0] a, input logic [1:0] op, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr <= a; cpu_op <= op; cpu_wdata <= d; cpu_wr <= 1'b1;
    @(posedge mclk);
    cpu_wr <= 1'b0;
    @(negedge mclk);
  endtask
  // Read strobe; data is valid after the sampling edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    cpu_addr <= a; cpu_rd <= 1'b1;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    @(negedge mclk);
    chk(cpu_rdata, exp);
  endtask
  task automatic print_verdict;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #(3000 * 100);
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd(16'hFF01, 8'h00);
    chk(pin_out, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rd(pu_addr[i], 8'h00);
      wr(pu_addr[i], 2'h0, 8'hFF);
      rd(pu_addr[i], pu_mask[i]);
    end
    rd(16'hFF20, 8'h00);
    $display("test registers done");
    @(posedge mclk);
    dir <= 8'h00;
    wr(16'hFF01, 2'h0, 8'hA5);
    chk(pin_in, 8'hA5);
    chk(pin_oe, 8'hFF);
    wr(16'hFF01, 2'h1, 8'h0F);
    rd(16'hFF01, 8'h05);
    wr(16'hFF01, 2'h3, 8'hF0);
    wr(16'hFF01, 2'h2, 8'hFF);
    rd(16'hFF01, 8'h0A);
    chk(pin_out, 8'h0A);
    chk(pullup_on, 8'h00);
    $display("test output mode done");
    @(posedge mclk);
    dir <= 8'hFF;
    drv <= 8'hFF;
    lvl <= 8'h3C;
    wr(16'hFF01, 2'h0, 8'h81);
    chk(pin_out, 8'h81);
    chk(pin_in, 8'h3C);
    chk(pin_oe, 8'h00);
    repeat (5) @(posedge mclk);
    rd(16'hFF01, 8'h3C);
    chk(pin_out, 8'h81);
    wr(16'hFF01, 2'h3, 8'h01);
    chk(pin_out, 8'h3D);
    $display("test input mode done");
    @(posedge mclk);
    drv <= 8'h00;
    alt <= 8'h0F;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk(pullup_on, 8'hF0);
    rd(16'hFF01, 8'hF0 | 8'h3C);
    @(posedge mclk);
    dir <= 8'h0F;
    alt <= 8'h00;
    drv <= 8'h0F;
    lvl <= 8'h06;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk(pullup_on, 8'h0F);
    chk(pin_oe, 8'hF0);
    // Output pins take the latch as operand, input pins the filtered level
    wr(16'hFF01, 2'h1, 8'hFE);
    chk(pin_out, 8'h36);
    $display("test pull-up done");
    // Reset in mid-run with a non-zero latch and pull-up selections set
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk(pin_out, 8'h00);
    chk(pullup_on, 8'h00);
    $display("test reset done");
    print_verdict();
  end
endmodule
